// ### common/timeout_reset_flag_pkg.sv
// constants, field layout and types of the watchdog and reset-cause block
// assumes a 10 MHz system clock and fuse levels that stay static

package timeout_reset_flag_pkg;

	// ****************************************
	// register bus
	// ****************************************
	localparam int unsigned ADDR_W = 2;
	localparam int unsigned DATA_W = 8;

	localparam logic [1:0] ADDR_CAUSE = 2'h0;
	localparam logic [1:0] ADDR_CTRL  = 2'h1;

	// ****************************************
	// reset cause register layout
	// ****************************************
	localparam int unsigned FLAG_W         = 5;
	localparam int unsigned FLAG_POWER_UP  = 0;
	localparam int unsigned FLAG_PIN       = 1;
	localparam int unsigned FLAG_SUPPLY    = 2;
	localparam int unsigned FLAG_TIMEOUT   = 3;
	localparam int unsigned FLAG_DEBUG     = 4;

	localparam logic [4:0] CAUSE_RESET       = 5'h01;
	localparam logic [4:0] LEGACY_FLAG_MASK  = 5'h03;

	// ****************************************
	// watchdog control register layout
	// ****************************************
	localparam int unsigned CTRL_UNLOCK    = 4;
	localparam int unsigned CTRL_ON        = 3;
	localparam int unsigned TSEL_W         = 3;

	localparam logic [2:0] TSEL_RESET      = 3'h0;
	localparam logic [2:0] UNLOCK_CYCLES   = 3'h4;

	// ****************************************
	// timeout counter
	// ****************************************
	localparam int unsigned CNT_W                = 22;
	localparam int unsigned TIMEOUT_BASE_DEFAULT = 16384;

	// ****************************************
	// synchroniser lanes
	// ****************************************
	localparam int unsigned SYNC_W         = 6;
	localparam int unsigned SYNC_OSC       = 0;
	localparam int unsigned SYNC_PIN       = 1;
	localparam int unsigned SYNC_SUPPLY    = 2;
	localparam int unsigned SYNC_DEBUG     = 3;
	localparam int unsigned SYNC_COMPAT    = 4;
	localparam int unsigned SYNC_ALWAYS_ON = 5;

	// ****************************************
	// safety levels
	// ****************************************
	typedef enum logic [1:0] {
		LEVEL0 = 2'b00,
		LEVEL1 = 2'b01,
		LEVEL2 = 2'b10
	} timeout_reset_flag_level_type;

endpackage

// ### hw/timeout_reset_flag_sync.sv
// two-stage synchroniser for a vector of independent levels
// assumes each lane is a slow level, not a multi-bit word

`timescale 1ns/1ps

module timeout_reset_flag_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clock_i,
	input  wire logic         reset_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} timeout_reset_flag_sync_state_type;

	timeout_reset_flag_sync_state_type state_reg;
	timeout_reset_flag_sync_state_type state_next;

	always_comb begin
		state_next        = state_reg;
		state_next.first  = async_i;
		state_next.second = state_reg.first;
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sync_o = state_reg.second;

endmodule

// ### hw/timeout_reset_flag_top.sv
// watchdog timer with reset-cause flags and fuse-selected safety level
// assumes reset_n_i is the power-up reset; other reset sources are pins
//
// Contract
// - debug-port flag bit 4 sets on debug reset; cleared by power-up or zero write.
// - timeout flag bit 3 sets on watchdog reset; cleared by power-up or zero write.
// - supply-drop flag bit 2 sets on brown-out reset; cleared likewise.
// - pin flag bit 1 sets on external pin reset; cleared likewise.
// - power-up flag bit 0 sets on power-up; only a zero write clears it.
// - legacy mode keeps only pin and power-up flags.
// - counter advances on the dedicated watchdog oscillator, not system clock.
// - counter restarts on restart instruction, on disable, on any chip reset.
// - elapsed timeout without restart issues a system reset.
// - two fuses pick level 0, 1 or 2 and the initial enable.
// - level 2 keeps the watchdog enabled; nothing disables it.
// - levels 1 and 2 accept timeout changes only while unlocked.
// - writing one to the on bit enables at every level.
// - hardware clears the unlock bit four clock cycles after setting.
// - zero to the on bit disables only while unlocked.
// - control bits 7 to 5 read as zero.
// - timeout select picks 16384 doubling up to 2097152 oscillator cycles.
// - at level 2 the on bit reads as one.
// - expiry gives a one-cycle system reset pulse.

`timescale 1ns/1ps

module timeout_reset_flag_top
	import timeout_reset_flag_pkg::*;
#(
	parameter int unsigned TIMEOUT_BASE = TIMEOUT_BASE_DEFAULT
) (
	input  wire logic                        clock_i,
	input  wire logic                        reset_n_i,
	input  wire logic                        wdt_osc_i,
	input  wire logic                        restart_i,
	input  wire logic                        pin_reset_i,
	input  wire logic                        supply_drop_reset_i,
	input  wire logic                        debug_reset_i,
	input  wire logic                        legacy_compat_fuse_i,
	input  wire logic                        watchdog_always_on_fuse_i,
	input  wire logic [timeout_reset_flag_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [timeout_reset_flag_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	output logic      [timeout_reset_flag_pkg::DATA_W-1:0] rdata_o,
	output logic                             system_reset_o,
	output logic                             wdt_on_o,
	output logic      [1:0]                  safety_level_o
);

	import timeout_reset_flag_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		timeout_reset_flag_level_type     level;
		logic               on;
		logic [2:0]         ucnt;
		logic [TSEL_W-1:0]  tsel;
		logic [FLAG_W-1:0]  flags;
		logic [CNT_W-1:0]   cnt;
		logic               osc_prev;
		logic               sys_rst;
		logic [DATA_W-1:0]  rdata;
	} timeout_reset_flag_state_type;

	localparam timeout_reset_flag_state_type STATE_RESET = '{
		level:    LEVEL1,
		on:       1'b0,
		ucnt:     3'h0,
		tsel:     TSEL_RESET,
		flags:    CAUSE_RESET,
		cnt:      '0,
		osc_prev: 1'b0,
		sys_rst:  1'b0,
		rdata:    '0
	};

	timeout_reset_flag_state_type      state_reg;
	timeout_reset_flag_state_type      state_next;

	logic [SYNC_W-1:0]   sync_in;
	logic [SYNC_W-1:0]   sync_s;
	logic                tick;
	logic                ext_rst;
	logic                expire;
	logic                unlock_q;
	logic                wr_ctrl;
	logic                wr_cause;
	logic                legacy;
	logic [CNT_W-1:0]    last_cnt;
	logic [FLAG_W-1:0]   set_mask;
	logic [FLAG_W-1:0]   impl_mask;

	// ****************************************
	// foreign inputs
	// ****************************************
	assign sync_in[SYNC_OSC]       = wdt_osc_i;
	assign sync_in[SYNC_PIN]       = pin_reset_i;
	assign sync_in[SYNC_SUPPLY]    = supply_drop_reset_i;
	assign sync_in[SYNC_DEBUG]     = debug_reset_i;
	assign sync_in[SYNC_COMPAT]    = legacy_compat_fuse_i;
	assign sync_in[SYNC_ALWAYS_ON] = watchdog_always_on_fuse_i;

	timeout_reset_flag_sync #(
		.W (SYNC_W)
	) u_sync (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.async_i   (sync_in),
		.sync_o    (sync_s)
	);

	// ****************************************
	// decode helpers
	// ****************************************
	assign unlock_q  = (state_reg.ucnt != 3'h0);
	assign wr_ctrl   = wr_i && (addr_i == ADDR_CTRL);
	assign wr_cause  = wr_i && (addr_i == ADDR_CAUSE);
	assign legacy    = sync_s[SYNC_COMPAT];
	assign impl_mask = legacy ? LEGACY_FLAG_MASK : {FLAG_W{1'b1}};

	// oscillator edge, counted at the system clock
	assign tick = sync_s[SYNC_OSC] && !state_reg.osc_prev;

	assign ext_rst = sync_s[SYNC_PIN] || sync_s[SYNC_SUPPLY] || sync_s[SYNC_DEBUG];

	// doubling timeout per select code
	assign last_cnt = (CNT_W'(TIMEOUT_BASE) << state_reg.tsel) - CNT_W'(1);

	assign expire = state_reg.on && tick && (state_reg.cnt == last_cnt)
		&& !restart_i && !ext_rst;

	always_comb begin
		set_mask                = '0;
		set_mask[FLAG_DEBUG]    = sync_s[SYNC_DEBUG];
		set_mask[FLAG_TIMEOUT]  = expire;
		set_mask[FLAG_SUPPLY]   = sync_s[SYNC_SUPPLY];
		set_mask[FLAG_PIN]      = sync_s[SYNC_PIN];
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		state_next          = state_reg;
		state_next.osc_prev = sync_s[SYNC_OSC];
		state_next.sys_rst  = expire;
		state_next.rdata    = '0;

		// fuse level
		unique case ({sync_s[SYNC_ALWAYS_ON], sync_s[SYNC_COMPAT]})
			2'b00: begin
				state_next.level = LEVEL1;
			end
			2'b01: begin
				state_next.level = LEVEL0;
			end
			2'b10, 2'b11: begin
				state_next.level = LEVEL2;
			end
		endcase

		// unlock window countdown
		if (unlock_q) begin
			state_next.ucnt = state_reg.ucnt - 3'h1;
		end

		// control writes
		if (wr_ctrl) begin
			if (wdata_i[CTRL_ON]) begin
				state_next.on = 1'b1;
			end else if (unlock_q) begin
				state_next.on = 1'b0;
			end
			if ((state_reg.level == LEVEL0) || unlock_q) begin
				state_next.tsel = wdata_i[TSEL_W-1:0];
			end
			if (wdata_i[CTRL_UNLOCK] && wdata_i[CTRL_ON]) begin
				state_next.ucnt = UNLOCK_CYCLES;
			end else begin
				state_next.ucnt = 3'h0;
			end
		end

		// chip reset from pins or expiry
		if (ext_rst || expire) begin
			state_next.on   = 1'b0;
			state_next.ucnt = 3'h0;
			state_next.tsel = TSEL_RESET;
		end

		// level 2 holds the watchdog on
		if (state_reg.level == LEVEL2) begin
			state_next.on = 1'b1;
		end

		// timeout counter
		if (restart_i || !state_reg.on || ext_rst || expire) begin
			state_next.cnt = '0;
		end else if (tick) begin
			state_next.cnt = state_reg.cnt + CNT_W'(1);
		end

		// cause flags, set wins over clear
		if (wr_cause) begin
			state_next.flags = state_reg.flags & wdata_i[FLAG_W-1:0];
		end
		state_next.flags = (state_next.flags | set_mask) & impl_mask;

		// register reads
		if (rd_i) begin
			unique case (addr_i)
				ADDR_CAUSE: begin
					state_next.rdata = {3'h0, state_reg.flags};
				end
				ADDR_CTRL: begin
					state_next.rdata = {3'h0, unlock_q, state_reg.on, state_reg.tsel};
				end
				default: begin
					state_next.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rdata_o        = state_reg.rdata;
	assign system_reset_o = state_reg.sys_rst;
	assign wdt_on_o       = state_reg.on;
	assign safety_level_o = state_reg.level;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clock_i);
	endclocking

	default disable iff (!reset_n_i);

	sequence seq_open;
		wr_ctrl && wdata_i[CTRL_UNLOCK] && wdata_i[CTRL_ON] && !ext_rst && !expire;
	endsequence

	sequence seq_quiet4;
		(!wr_i && !ext_rst && !expire)[*4];
	endsequence

	chk_unlock_open: assert property (
		seq_open |=> unlock_q
	) else $error("unlock window did not open");

	chk_unlock_close: assert property (
		seq_open ##1 seq_quiet4 |=> !unlock_q
	) else $error("unlock window not closed after four cycles");

	chk_level2_on: assert property (
		(state_reg.level == LEVEL2) |=> wdt_on_o
	) else $error("watchdog off at level 2");

	chk_level2_read: assert property (
		rd_i && (addr_i == ADDR_CTRL) && wdt_on_o && (state_reg.level == LEVEL2)
		|=> rdata_o[CTRL_ON]
	) else $error("on bit read zero at level 2");

	chk_reserved_zero: assert property (
		rd_i && (addr_i == ADDR_CTRL) |=> (rdata_o[7:5] == 3'h0)
	) else $error("reserved control bits not zero");

	chk_tsel_locked: assert property (
		wr_ctrl && !unlock_q && (state_reg.level != LEVEL0)
		|=> $stable(state_reg.tsel) || $past(ext_rst || expire)
	) else $error("timeout changed while locked");

	chk_on_write: assert property (
		wr_ctrl && wdata_i[CTRL_ON] && !ext_rst && !expire |=> wdt_on_o
	) else $error("write of one did not enable");

	chk_off_locked: assert property (
		wr_ctrl && !wdata_i[CTRL_ON] && !unlock_q && wdt_on_o && !ext_rst && !expire
		|=> wdt_on_o
	) else $error("watchdog disabled without unlock");

	chk_expire_pulse: assert property (
		system_reset_o |=> !system_reset_o
	) else $error("system reset pulse longer than one cycle");

	chk_expire_time: assert property (
		expire |=> system_reset_o && (state_reg.cnt == '0)
	) else $error("expiry did not reset the system");

	chk_timeout_flag: assert property (
		system_reset_o && !legacy |-> state_reg.flags[FLAG_TIMEOUT]
	) else $error("timeout flag missing after expiry");

	chk_pin_flag: assert property (
		sync_s[SYNC_PIN] |=> state_reg.flags[FLAG_PIN]
	) else $error("pin flag not set");

	chk_legacy_flags: assert property (
		legacy ##1 legacy |-> (state_reg.flags[FLAG_DEBUG:FLAG_SUPPLY] == 3'h0)
	) else $error("flag present in legacy mode");

	chk_restart_cnt: assert property (
		restart_i |=> (state_reg.cnt == '0)
	) else $error("restart did not clear counter");

	chk_debug_flag: assert property (
		sync_s[SYNC_DEBUG] && !legacy |=> state_reg.flags[FLAG_DEBUG]
	) else $error("debug flag not set");

	chk_supply_flag: assert property (
		sync_s[SYNC_SUPPLY] && !legacy |=> state_reg.flags[FLAG_SUPPLY]
	) else $error("supply drop flag not set");

	chk_power_flag_kept: assert property (
		state_reg.flags[FLAG_POWER_UP] && !(wr_cause && !wdata_i[FLAG_POWER_UP])
		|=> state_reg.flags[FLAG_POWER_UP]
	) else $error("power-up flag lost without zero write");

	chk_level_fuse: assert property (
		sync_s[SYNC_ALWAYS_ON] |=> (safety_level_o == 2'h2)
	) else $error("always-on fuse did not give level 2");

	chk_tsel_free: assert property (
		wr_ctrl && (state_reg.level == LEVEL0) && !ext_rst && !expire
		|=> (state_reg.tsel == $past(wdata_i[TSEL_W-1:0]))
	) else $error("timeout not taken at level 0");

endmodule

// ### tb/timeout_reset_flag_tb.sv
// self-checking bench for the watchdog and reset-cause block
// assumes timeout_reset_flag_pkg and hw/ files are compiled first

`timescale 1ns/1ps

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("FAIL %s exp %0h got %0h", n, e, g); end end

module testbench;
	import timeout_reset_flag_pkg::*;

	localparam int unsigned TB_BASE = 4;

	logic              clock_i = 0;
	logic              reset_n_i = 0;
	logic              wdt_osc_i = 0;
	logic              restart_i = 0;
	logic              pin_reset_i = 0;
	logic              supply_drop_reset_i = 0;
	logic              debug_reset_i = 0;
	logic              legacy_compat_fuse_i = 0;
	logic              watchdog_always_on_fuse_i = 0;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [DATA_W-1:0] wdata_i = '0;
	logic              wr_i = 0;
	logic              rd_i = 0;
	logic [DATA_W-1:0] rdata_o;
	logic              system_reset_o;
	logic              wdt_on_o;
	logic [1:0]        safety_level_o;
	int                n_mismatch = 0;
	int                checks_done = 0;
	int                hit;
	int                pulses;
	logic [2:0]        codes [3] = '{3'h0, 3'h1, 3'h7};
	logic [7:0]        flags [3] = '{8'h03, 8'h04, 8'h10};

	always #50 clock_i = ~clock_i;

	timeout_reset_flag_top #(.TIMEOUT_BASE(TB_BASE)) DUT (
		.clock_i                   (clock_i),
		.reset_n_i                 (reset_n_i),
		.wdt_osc_i                 (wdt_osc_i),
		.restart_i                 (restart_i),
		.pin_reset_i               (pin_reset_i),
		.supply_drop_reset_i       (supply_drop_reset_i),
		.debug_reset_i             (debug_reset_i),
		.legacy_compat_fuse_i      (legacy_compat_fuse_i),
		.watchdog_always_on_fuse_i (watchdog_always_on_fuse_i),
		.addr_i                    (addr_i),
		.wdata_i                   (wdata_i),
		.wr_i                      (wr_i),
		.rd_i                      (rd_i),
		.rdata_o                   (rdata_o),
		.system_reset_o            (system_reset_o),
		.wdt_on_o                  (wdt_on_o),
		.safety_level_o            (safety_level_o)
	);

	// ****************************************
	// bus and stimulus tasks
	// ****************************************
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] e, input string n);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		`CHK(n, e, rdata_o)
	endtask

	task automatic do_reset(input logic c, input logic a);
		@(posedge clock_i);
		reset_n_i <= 1'b0;
		legacy_compat_fuse_i <= c;
		watchdog_always_on_fuse_i <= a;
		repeat (6) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (5) @(posedge clock_i);
		#1;
	endtask

	// s: 0 pin, 1 supply drop, 2 debug
	task automatic ev(input int s);
		@(posedge clock_i);
		pin_reset_i <= (s == 0);
		supply_drop_reset_i <= (s == 1);
		debug_reset_i <= (s == 2);
		repeat (4) @(posedge clock_i);
		pin_reset_i <= 1'b0;
		supply_drop_reset_i <= 1'b0;
		debug_reset_i <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask

	// oscillator at ten clocks a period, optional restart every n periods
	task automatic run_osc(input int periods, input int every);
		hit = 0;
		pulses = 0;
		for (int p = 1; p <= periods; p++) begin
			for (int k = 0; k < 10; k++) begin
				@(posedge clock_i);
				wdt_osc_i <= (k < 5);
				restart_i <= (every != 0 && k == 0 && p % every == 0);
				#1;
				if (system_reset_o === 1'b1) begin
					pulses++;
					if (hit == 0) hit = p;
				end
			end
		end
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		#3000000;
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		do_reset(1'b0, 1'b0);
		`CHK("level", 2'd1, safety_level_o)
		`CHK("on", 1'b0, wdt_on_o)
		rd(ADDR_CAUSE, 8'h01, "cause");
		rd(2'h2, 8'h00, "unmapped");
		wr(2'h3, 8'hff);
		wr(ADDR_CTRL, 8'h08);
		for (int s = 0; s < 3; s++) begin
			ev(s);
			rd(ADDR_CAUSE, flags[s], "flag");
			wr(ADDR_CAUSE, 8'h00);
		end
		rd(ADDR_CAUSE, 8'h00, "cleared");
		rd(ADDR_CTRL, 8'h00, "chip reset ctrl");
		$display("test flags done");

		wr(ADDR_CTRL, 8'he8);
		`CHK("on", 1'b1, wdt_on_o)
		rd(ADDR_CTRL, 8'h08, "reserved");
		wr(ADDR_CTRL, 8'h07);
		rd(ADDR_CTRL, 8'h08, "locked");
		wr(ADDR_CTRL, 8'h18);
		rd(ADDR_CTRL, 8'h18, "window");
		repeat (4) @(posedge clock_i);
		rd(ADDR_CTRL, 8'h08, "closed");
		wr(ADDR_CTRL, 8'h00);
		`CHK("late off", 1'b1, wdt_on_o)
		wr(ADDR_CTRL, 8'h18);
		wr(ADDR_CTRL, 8'h02);
		`CHK("off", 1'b0, wdt_on_o)
		rd(ADDR_CTRL, 8'h02, "tsel");
		$display("test control done");

		foreach (codes[i]) begin
			wr(ADDR_CTRL, 8'h18);
			wr(ADDR_CTRL, {5'h01, codes[i]});
			run_osc((TB_BASE << codes[i]) + 2, 0);
			`CHK("expiry", TB_BASE << codes[i], hit)
			`CHK("pulse", 1, pulses)
			`CHK("on", 1'b0, wdt_on_o)
			rd(ADDR_CAUSE, 8'h08, "timeout");
			wr(ADDR_CAUSE, 8'h00);
		end
		wr(ADDR_CTRL, 8'h08);
		run_osc(12, 2);
		`CHK("restart", 0, hit)
		wr(ADDR_CTRL, 8'h18);
		wr(ADDR_CTRL, 8'h00);
		run_osc(8, 0);
		`CHK("disabled", 0, hit)
		$display("test timeout done");

		do_reset(1'b0, 1'b1);
		`CHK("level", 2'd2, safety_level_o)
		`CHK("on", 1'b1, wdt_on_o)
		wr(ADDR_CTRL, 8'h18);
		wr(ADDR_CTRL, 8'h00);
		`CHK("on", 1'b1, wdt_on_o)
		wr(ADDR_CTRL, 8'h07);
		rd(ADDR_CTRL, 8'h08, "lvl2");
		wr(ADDR_CTRL, 8'h18);
		wr(ADDR_CTRL, 8'h02);
		rd(ADDR_CTRL, 8'h0a, "lvl2 tsel");
		$display("test level 2 done");

		do_reset(1'b1, 1'b0);
		`CHK("level", 2'd0, safety_level_o)
		wr(ADDR_CTRL, 8'h0b);
		rd(ADDR_CTRL, 8'h0b, "lvl0");
		wr(ADDR_CAUSE, 8'h00);
		ev(1);
		ev(2);
		rd(ADDR_CAUSE, 8'h00, "legacy");
		ev(0);
		rd(ADDR_CAUSE, 8'h02, "legacy pin");
		$display("test legacy done");

		do_reset(1'b1, 1'b1);
		`CHK("level", 2'd2, safety_level_o)
		`CHK("on", 1'b1, wdt_on_o)
		ev(1);
		`CHK("on", 1'b1, wdt_on_o)
		rd(ADDR_CAUSE, 8'h01, "both fuses");
		$display("test both fuses done");
		tally_and_finish();
	end
endmodule
